// *** inc/clock_mode_pkg.sv ***
// Constants and types for the dual clock mode controller
package clock_mode_pkg;
   localparam logic [4:0] clock_status_port_addr  = 5'h0e;
   localparam logic [4:0] clock_mode_command_addr = 5'h16;
   localparam logic [3:0] command_reset_value     = 4'h0;
   localparam int         mode_field_lsb          = 2;
   localparam int         warmup_field_lsb        = 0;
   localparam int         status_mode_bit         = 0;
   localparam int         status_stable_bit       = 1;
   localparam logic [1:0] mode_normal_code        = 2'h0;
   localparam logic [1:0] mode_slow_code          = 2'h1;
   localparam logic [1:0] warmup_short_code       = 2'h1;
   localparam logic [11:0] warmup_short_cycles    = 12'h100;
   localparam logic [11:0] warmup_long_cycles     = 12'h800;
   // Low oscillator cycles seen before it is called stable
   localparam logic [11:0] stable_cycles          = 12'h100;

   typedef enum logic [1:0] {
      state_normal = 2'b00,
      state_slow   = 2'b01,
      state_warmup = 2'b10
   } clock_state_t;

   typedef struct packed {
      logic       write;
      logic [4:0] addr;
      logic [3:0] data;
   } port_write_t;
endpackage : clock_mode_pkg

// *** rtl/low_clock_edge.sv ***
// Synchroniser and rising edge detector for the low-frequency clock
module low_clock_edge (
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic low_freq_clock,
   output logic      low_edge
);
   logic sync1_reg;
   logic sync2_reg;
   logic last_reg;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         last_reg  <= 1'b0;
      end else begin
         sync1_reg <= low_freq_clock;
         sync2_reg <= sync1_reg;
         last_reg  <= sync2_reg;
      end
   end

   assign low_edge = sync2_reg & ~last_reg;
endmodule : low_clock_edge

// *** rtl/dual_clock_mode_controller.sv ***
// Dual clock mode controller: command port, status port, warm-up sequencing
module dual_clock_mode_controller (
   input  wire logic                        clock,
   input  wire logic                        reset_n,
   input  wire logic                        low_freq_clock,
   input  wire clock_mode_pkg::port_write_t port_write,
   input  wire logic [4:0]                  read_addr,
   output logic [3:0]                       read_data,
   output logic                             high_osc_enable,
   output logic                             low_osc_enable,
   output logic                             cpu_clock_select_low
);
   import clock_mode_pkg::*;

   // One system clock pulse per rising edge of the low clock
   logic         low_edge;

   // Command port
   logic         command_addr_hit;
   logic         command_write;
   logic [3:0]   command_reg;
   logic [3:0]   command_next;
   logic [1:0]   mode_select_field;
   logic [1:0]   warmup_time_field;
   logic         write_selects_slow;
   logic         write_selects_normal;

   // Mode sequencing
   clock_state_t state_reg;
   clock_state_t state_next;
   logic [11:0]  warm_count_reg;
   logic [11:0]  warm_count_next;
   logic [11:0]  warm_target;
   logic         warm_done;

   // Low oscillator stability
   logic [11:0]  stable_count_reg;
   logic [11:0]  stable_count_next;
   logic         stable_count_run;
   logic         stable_reached;
   logic         stable_reg;
   logic         stable_next;

   // Output and status flops
   logic         high_osc_enable_reg;
   logic         high_osc_enable_next;
   logic         cpu_select_low_reg;
   logic         cpu_select_low_next;
   logic [3:0]   status_reg;
   logic [3:0]   status_next;

   // Status read
   logic         status_addr_hit;

   // The low clock pin is asynchronous; two flops stand before any logic sees it
   low_clock_edge low_clock_edge_inst (
      .clock          (clock),
      .reset_n        (reset_n),
      .low_freq_clock (low_freq_clock),
      .low_edge       (low_edge)
   );

   assign command_addr_hit = (port_write.addr == clock_mode_command_addr);
   assign command_write    = port_write.write && command_addr_hit;
   assign command_next     = command_write ? port_write.data : command_reg;

   // Mode is decoded from the incoming value so a write acts at its own edge
   assign mode_select_field = command_next[mode_field_lsb +: 2];
   assign warmup_time_field = command_reg[warmup_field_lsb +: 2];

   // Reserved mode codes match neither and leave the mode alone
   assign write_selects_slow   = command_write && (mode_select_field == mode_slow_code);
   assign write_selects_normal = command_write && (mode_select_field == mode_normal_code);

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         command_reg <= command_reset_value;
      end else begin
         command_reg <= command_next;
      end
   end

   // Warm-up length in low clock edges
   always_comb begin
      if (warmup_time_field == warmup_short_code) begin
         warm_target = warmup_short_cycles;
      end else begin
         // Reserved code 00 gets the long interval so the oscillator always settles
         warm_target = warmup_long_cycles;
      end
   end

   assign warm_done = (warm_count_reg == warm_target - 12'h001);

   // SLOW is entered on the write alone; software polls stability first
   always_comb begin
      state_next      = state_reg;
      warm_count_next = warm_count_reg;
      unique case (state_reg)
         state_normal: begin
            if (write_selects_slow) begin
               state_next = state_slow;
            end
         end
         state_slow: begin
            if (write_selects_normal) begin
               state_next      = state_warmup;
               warm_count_next = 12'h000;
            end
         end
         state_warmup: begin
            // A new SLOW command abandons the warm-up; the CPU never left the low clock
            if (write_selects_slow) begin
               state_next = state_slow;
            end else if (low_edge) begin
               warm_count_next = warm_count_reg + 12'h001;
               if (warm_done) begin
                  state_next = state_normal;
               end
            end
         end
         default: begin
            state_next = state_normal;
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= state_normal;
      end else begin
         state_reg <= state_next;
      end
   end

   // Only meaningful during warm-up; each return command from SLOW restarts it
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         warm_count_reg <= 12'h000;
      end else begin
         warm_count_reg <= warm_count_next;
      end
   end

   // Stability: low clock edges counted from reset; once set the flag stays set
   // Limitation: only the edge count is judged, not the frequency
   assign stable_count_run = low_edge && !stable_reg;
   assign stable_reached   = stable_count_run && (stable_count_reg == stable_cycles - 12'h001);

   always_comb begin
      stable_count_next = stable_count_reg;
      if (stable_count_run) begin
         stable_count_next = stable_count_reg + 12'h001;
      end
   end

   assign stable_next = stable_reg || stable_reached;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stable_count_reg <= 12'h000;
      end else begin
         stable_count_reg <= stable_count_next;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stable_reg <= 1'b0;
      end else begin
         stable_reg <= stable_next;
      end
   end

   // Outputs follow the next mode so they move on the same edge as the mode
   assign high_osc_enable_next = (state_next != state_slow);
   assign cpu_select_low_next  = (state_next != state_normal);

   always_comb begin
      status_next                    = 4'h0;
      status_next[status_mode_bit]   = (state_next != state_normal);
      status_next[status_stable_bit] = stable_next;
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         high_osc_enable_reg <= 1'b1;
      end else begin
         high_osc_enable_reg <= high_osc_enable_next;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cpu_select_low_reg <= 1'b0;
      end else begin
         cpu_select_low_reg <= cpu_select_low_next;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         status_reg <= 4'h0;
      end else begin
         status_reg <= status_next;
      end
   end

   assign high_osc_enable      = high_osc_enable_reg;
   assign cpu_clock_select_low = cpu_select_low_reg;
   // The low oscillator is never stopped: SLOW runs from it and warm-up counts it
   assign low_osc_enable       = 1'b1;

   // Status read port; other addresses read zero
   assign status_addr_hit = (read_addr == clock_status_port_addr);

   always_comb begin
      read_data = 4'h0;
      if (status_addr_hit) begin
         read_data = status_reg;
      end
   end
endmodule : dual_clock_mode_controller

// *** test/dual_clock_mode_monitor.sv ***
// Port checker for the dual clock mode controller
module dual_clock_mode_monitor (
   input wire logic                        clock,
   input wire logic                        reset_n,
   input wire logic                        low_freq_clock,
   input wire clock_mode_pkg::port_write_t port_write,
   input wire logic [4:0]                  read_addr,
   input wire logic [3:0]                  read_data,
   input wire logic                        high_osc_enable,
   input wire logic                        low_osc_enable,
   input wire logic                        cpu_clock_select_low
);
   timeunit 1ns;
   timeprecision 1ps;
   import clock_mode_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   logic cmd;
   assign cmd = port_write.write && port_write.addr == 5'h16;
   chk_low_osc_on: assert property (low_osc_enable) else $error("low osc off");
   chk_slow_entry: assert property (cmd && port_write.data[3:2] == 2'h1 |=>
      !high_osc_enable && cpu_clock_select_low) else $error("slow not entered");
   chk_reserved_mode: assert property (cmd && port_write.data[3] && high_osc_enable != cpu_clock_select_low
      |=> $stable(high_osc_enable) && $stable(cpu_clock_select_low)) else $error("reserved mode acted");
   chk_status_mode: assert property (read_addr == 5'h0e |->
      read_data[0] == cpu_clock_select_low) else $error("mode bit wrong");
   chk_warmup_hold: assert property (cmd && port_write.data == 4'h1 && !high_osc_enable
      |=> (high_osc_enable && cpu_clock_select_low) [*8]) else $error("warm-up cut short");
   chk_reset_normal: assert property ($rose(reset_n) |->
      high_osc_enable && !cpu_clock_select_low) else $error("not normal after reset");
   chk_normal_high: assert property (!cpu_clock_select_low |-> high_osc_enable) else $error("high osc off");
   chk_stable_sticky: assert property (read_addr == 5'h0e && read_data[1] ##1 read_addr == 5'h0e
      |-> read_data[1]) else $error("stable flag dropped");
   chk_leave_cause: assert property ($fell(cpu_clock_select_low) |->
      $past(high_osc_enable)) else $error("switched before high osc ran");
endmodule : dual_clock_mode_monitor
bind dual_clock_mode_controller dual_clock_mode_monitor dual_clock_mode_monitor_inst (.clock(clock),
   .reset_n(reset_n), .low_freq_clock(low_freq_clock), .port_write(port_write), .read_addr(read_addr),
   .read_data(read_data), .high_osc_enable(high_osc_enable), .low_osc_enable(low_osc_enable),
   .cpu_clock_select_low(cpu_clock_select_low));

// *** test/tb_top.sv ***
// Self-checking bench for the dual clock mode controller
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import clock_mode_pkg::*;
   logic        clock = 0, reset_n = 0, low_freq_clock = 0, high_en, low_en, sel_low;
   port_write_t pw = '0;
   logic [3:0]  read_data;
   logic [4:0]  ra = 5'h0e;
   int          errors = 0, tests_run = 0, edges = 0;
   dual_clock_mode_controller dual_clock_mode_controller_inst (.clock(clock), .reset_n(reset_n),
      .low_freq_clock(low_freq_clock), .port_write(pw), .read_addr(ra), .read_data(read_data),
      .high_osc_enable(high_en), .low_osc_enable(low_en), .cpu_clock_select_low(sel_low));
   initial forever #2.5 clock = ~clock;
   // Free-running oscillator, eight system clocks a period, unrelated phase
   initial forever #20.3 low_freq_clock = ~low_freq_clock;
   always @(posedge low_freq_clock) edges++;
   task check(string name, logic [11:0] exp, logic [11:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task give_verdict();
      if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict
   task put(logic [4:0] a, logic [3:0] d);
      @(negedge clock) pw = '{1'b1, a, d};
      @(negedge clock) pw.write = 1'b0;
   endtask : put
   // Packs high enable, low select and status into one word
   task state(string name, logic [5:0] exp);
      check(name, {6'h0, exp}, {6'h0, high_en, sel_low, read_data});
   endtask : state
   task t_slow();
      repeat (3000) if (!read_data[1]) @(negedge clock);
      state("stable normal", 6'h22);
      // Only the clock ports are used; nothing runs at the fast rates while SLOW
      put(5'h16, 4'h4);
      @(negedge clock);
      state("slow", 6'h13);
   endtask : t_slow
   task t_wake(logic [1:0] code, int n);
      int e0;
      e0 = edges;
      put(5'h16, {2'b00, code});
      state("warm-up", 6'h33);
      repeat (20000) if (sel_low) @(negedge clock);
      e0 = edges - e0;
      // One edge of slack either side for synchroniser phase
      check("warm-up edges", n, (e0 >= n - 1 && e0 <= n + 1) ? n : e0);
      state("back to normal", 6'h22);
   endtask : t_wake
   initial begin
      repeat (10) @(negedge clock);
      reset_n = 1;
      @(negedge clock);
      state("after reset", 6'h20);
      t_slow();
      put(5'h16, 4'h8);
      put(5'h0e, 4'h0);
      state("reserved ignored", 6'h13);
      @(negedge clock) ra = 5'h16;
      #1 check("other address", 12'h0, {8'h0, read_data});
      @(negedge clock) ra = 5'h0e;
      t_wake(2'h1, 256);
      // c = 4 wraps to the reserved code 00, which runs the long interval
      for (int c = 2; c < 5; c++) begin
         t_slow();
         t_wake(c[1:0], 2048);
      end
      t_slow();
      @(negedge clock) reset_n = 0;
      #1 state("reset in slow", 6'h20);
      @(negedge clock) reset_n = 1;
      @(negedge clock) state("after second reset", 6'h20);
      give_verdict();
   end
   initial begin
      #400000;
      errors++;
      give_verdict();
   end
endmodule : tb_top
